// *** src/fsk_pkg.sv ***
// Shared constants and types for the caller data serial output block
package fsk_pkg;

    // ************************************************************
    // Clock and derived timing
    // ************************************************************
    localparam int REF_CLK_HZ      = 100_000_000;
    localparam int CYC_PER_US      = REF_CLK_HZ / 1_000_000;
    localparam int CARRIER_TIME_US = 8000;
    localparam int CARRIER_CYC     = CARRIER_TIME_US * CYC_PER_US;
    localparam int BAUD_RATE       = 1200;
    localparam int BIT_CYC         = REF_CLK_HZ / BAUD_RATE;
    localparam int HALF_BIT_DIV    = 2400;
    localparam int HALF_BIT_CYC    = REF_CLK_HZ / HALF_BIT_DIV;

    // ************************************************************
    // Short internal intervals
    // ************************************************************
    localparam int ENABLE_CYC        = 1000;
    localparam int GUARD_PRESENT_CYC = 2000;
    localparam int GUARD_ABSENT_CYC  = 2000;
    localparam int SWITCH_CYC        = 16;

    // ************************************************************
    // Widths, indices and reset values
    // ************************************************************
    localparam int          CNT_W        = 20;
    localparam int          SYNC_W       = 7;
    localparam logic [3:0]  LAST_DATA    = 4'h7;
    localparam logic [3:0]  BYTE_BITS    = 4'h8;
    localparam logic [7:0]  SHIFT_RST    = 8'hFF;

    typedef enum logic [3:0] {
        RX_IDLE  = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA  = 4'b0100,
        RX_STOP  = 4'b1000
    } fsk_rx_state_t;

endpackage

// *** src/fsk_sync.sv ***
// Two flip-flop synchroniser for a group of pin levels
`timescale 1ns/100ps
module fsk_sync
    import fsk_pkg::*;
#(
    parameter int W = SYNC_W
)(
    input  wire logic         ref_clk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] asyncIn,
    output logic      [W-1:0] syncOut
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // ************************************************************
    // First stage feeds only the second
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= asyncIn;
            sync_q <= meta_q;
        end
    end

    assign syncOut = sync_q;

endmodule // fsk_sync

// *** src/fsk_hold_filter.sv ***
// Level qualifier with separate assert and release hold counts
`timescale 1ns/100ps
module fsk_hold_filter
    import fsk_pkg::*;
#(
    parameter int ON_CYC  = 8,
    parameter int OFF_CYC = 8
)(
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    input  wire logic levelIn,
    output logic      levelOut
);
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic             out_q;
    logic             out_d;

    // ************************************************************
    // Any agreement restarts the count, so dropouts are masked
    // ************************************************************
    always_comb begin
        cnt_d = cnt_q;
        out_d = out_q;
        if (levelIn == out_q) begin
            cnt_d = '0;
        end else if (levelIn && cnt_q == CNT_W'(ON_CYC - 1)) begin
            out_d = 1'b1;
            cnt_d = '0;
        end else if (!levelIn && cnt_q == CNT_W'(OFF_CYC - 1)) begin
            out_d = 1'b0;
            cnt_d = '0;
        end else begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cnt_q <= '0;
            out_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            out_q <= out_d;
        end
    end

    assign levelOut = out_q;

endmodule // fsk_hold_filter

// *** src/fsk_tone_detect_serial_out.sv ***
// Alert tone qualifier, carrier detector and three-wire serial output
`timescale 1ns/100ps
module fsk_tone_detect_serial_out
    import fsk_pkg::*;
#(
    parameter int CARRIER_ON_CYC    = CARRIER_CYC,
    parameter int CARRIER_OFF_CYC   = CARRIER_CYC + 1,
    parameter int BIT_PERIOD_CYC    = BIT_CYC,
    parameter int READY_TIMEOUT_CYC = HALF_BIT_CYC
)(
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    input  wire logic demodSelect,
    input  wire logic outputInterfaceSelect,
    input  wire logic toneHighDet,
    input  wire logic toneLowDet,
    input  wire logic carrierAmpOk,
    input  wire logic demodBit,
    input  wire logic serialBitClockIn,
    output logic      serialBitClockOut,
    output logic      serialBitClockOeN,
    output logic      serialData,
    output logic      byteReadyN,
    output logic      carrierPresentN,
    output logic      tonePairRaw,
    output logic      tonePairQualified,
    output logic      guardDischarge,
    output logic      guardCharge
);
    localparam int QUARTER_CYC = BIT_PERIOD_CYC / 4;
    localparam int HALF_CYC    = BIT_PERIOD_CYC / 2;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [SYNC_W-1:0] pinsS;
    logic              demodSelS;
    logic              modeS;
    logic              toneHiS;
    logic              toneLoS;
    logic              carrierAmpS;
    logic              demodBitS;
    logic              extClkS;

    fsk_sync #(.W(SYNC_W)) u_sync (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .asyncIn ({demodSelect, outputInterfaceSelect, toneHighDet, toneLowDet,
                   carrierAmpOk, demodBit, serialBitClockIn}),
        .syncOut (pinsS)
    );

    assign {demodSelS, modeS, toneHiS, toneLoS, carrierAmpS, demodBitS, extClkS} = pinsS;

    // ************************************************************
    // Enable interval after each select change
    // ************************************************************
    logic             selPrev_q;
    logic             selPrev_d;
    logic [CNT_W-1:0] enCnt_q;
    logic [CNT_W-1:0] enCnt_d;
    logic             usable_q;
    logic             usable_d;
    logic             alertUsable;
    logic             demodUsable;

    always_comb begin
        selPrev_d = demodSelS;
        enCnt_d   = enCnt_q;
        usable_d  = usable_q;
        if (demodSelS != selPrev_q) begin
            enCnt_d  = '0;
            usable_d = 1'b0;
        end else if (!usable_q) begin
            if (enCnt_q == CNT_W'(ENABLE_CYC - 1)) begin
                usable_d = 1'b1;
            end else begin
                enCnt_d = enCnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            selPrev_q <= 1'b0;
            enCnt_q   <= '0;
            usable_q  <= 1'b0;
        end else begin
            selPrev_q <= selPrev_d;
            enCnt_q   <= enCnt_d;
            usable_q  <= usable_d;
        end
    end

    assign alertUsable = usable_q && !demodSelS;
    assign demodUsable = usable_q && demodSelS;

    // ************************************************************
    // Alert tone pair and guard time
    // ************************************************************
    logic             raw_q;
    logic             raw_d;
    logic             qualOut;
    logic             qualPrev_q;
    logic             qualPrev_d;
    logic [CNT_W-1:0] swCnt_q;
    logic [CNT_W-1:0] swCnt_d;
    logic             disch_q;
    logic             disch_d;
    logic             chg_q;
    logic             chg_d;

    // guard qualification of the raw detect
    fsk_hold_filter #(.ON_CYC(GUARD_PRESENT_CYC), .OFF_CYC(GUARD_ABSENT_CYC)) u_guard (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .levelIn  (raw_q),
        .levelOut (qualOut)
    );

    always_comb begin
        raw_d      = toneHiS && toneLoS && alertUsable;
        qualPrev_d = qualOut;
        swCnt_d    = swCnt_q;
        disch_d    = disch_q;
        chg_d      = chg_q;
        if (qualOut && !qualPrev_q) begin
            disch_d = 1'b1;
            chg_d   = 1'b0;
            swCnt_d = CNT_W'(SWITCH_CYC - 1);
        end else if (!qualOut && qualPrev_q) begin
            chg_d   = 1'b1;
            disch_d = 1'b0;
            swCnt_d = CNT_W'(SWITCH_CYC - 1);
        end else if (swCnt_q != '0) begin
            swCnt_d = swCnt_q - 1'b1;
        end else begin
            disch_d = 1'b0;
            chg_d   = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            raw_q      <= 1'b0;
            qualPrev_q <= 1'b0;
            swCnt_q    <= '0;
            disch_q    <= 1'b0;
            chg_q      <= 1'b0;
        end else begin
            raw_q      <= raw_d;
            qualPrev_q <= qualPrev_d;
            swCnt_q    <= swCnt_d;
            disch_q    <= disch_d;
            chg_q      <= chg_d;
        end
    end

    assign tonePairRaw       = raw_q;
    assign tonePairQualified = qualOut;
    assign guardDischarge    = disch_q;
    assign guardCharge       = chg_q;

    // ************************************************************
    // Carrier detector
    // ************************************************************
    logic carrierOn;

    // 8 ms assert, over 8 ms release
    fsk_hold_filter #(.ON_CYC(CARRIER_ON_CYC), .OFF_CYC(CARRIER_OFF_CYC)) u_carrier (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .levelIn  (carrierAmpS && demodUsable),
        .levelOut (carrierOn)
    );

    assign carrierPresentN = !carrierOn;

    // ************************************************************
    // Character receiver
    // ************************************************************
    fsk_rx_state_t    state_q;
    fsk_rx_state_t    state_d;
    logic [CNT_W-1:0] phase_q;
    logic [CNT_W-1:0] phase_d;
    logic [3:0]       bitIdx_q;
    logic [3:0]       bitIdx_d;
    logic [7:0]       rxShift_q;
    logic [7:0]       rxShift_d;
    logic             markPrev_q;
    logic             bitEnd;
    logic             atQuarter;
    logic             atHalf;
    logic             byteDone;

    assign bitEnd    = phase_q == CNT_W'(BIT_PERIOD_CYC - 1);
    assign atQuarter = phase_q == CNT_W'(QUARTER_CYC);
    assign atHalf    = phase_q == CNT_W'(HALF_CYC);
    assign byteDone  = (state_q == RX_STOP) && atHalf && carrierOn;

    always_comb begin
        state_d   = state_q;
        phase_d   = bitEnd ? '0 : phase_q + 1'b1;
        bitIdx_d  = bitIdx_q;
        rxShift_d = rxShift_q;
        if (!carrierOn) begin
            state_d = RX_IDLE;
            phase_d = '0;
        end else begin
            case (state_q)
                RX_IDLE: begin
                    phase_d = '0;
                    if (markPrev_q && !demodBitS) begin
                        state_d = RX_START;
                    end
                end
                RX_START: begin
                    // False start if the line is back at mark
                    if (atHalf && demodBitS) begin
                        state_d = RX_IDLE;
                    end else if (bitEnd) begin
                        state_d  = RX_DATA;
                        bitIdx_d = '0;
                    end
                end
                RX_DATA: begin
                    if (atQuarter) begin
                        rxShift_d[bitIdx_q[2:0]] = demodBitS;
                    end
                    if (bitEnd) begin
                        if (bitIdx_q == LAST_DATA) begin
                            state_d = RX_STOP;
                        end else begin
                            bitIdx_d = bitIdx_q + 1'b1;
                        end
                    end
                end
                RX_STOP: begin
                    // Leave at mid stop so the next start edge is seen
                    if (atHalf) begin
                        state_d = RX_IDLE;
                    end
                end
                default: begin
                    state_d = RX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_q    <= RX_IDLE;
            phase_q    <= '0;
            bitIdx_q   <= '0;
            rxShift_q  <= SHIFT_RST;
            markPrev_q <= 1'b1;
        end else begin
            state_q    <= state_d;
            phase_q    <= phase_d;
            bitIdx_q   <= bitIdx_d;
            rxShift_q  <= rxShift_d;
            markPrev_q <= demodBitS;
        end
    end

    // ************************************************************
    // Three-wire output
    // ************************************************************
    logic             clkOut_q;
    logic             clkOut_d;
    logic             data_q;
    logic             data_d;
    logic             readyN_q;
    logic             readyN_d;
    logic [CNT_W-1:0] rdyCnt_q;
    logic [CNT_W-1:0] rdyCnt_d;
    logic [7:0]       txShift_q;
    logic [7:0]       txShift_d;
    logic [3:0]       txLeft_q;
    logic [3:0]       txLeft_d;
    logic             extPrev_q;
    logic             extRise;

    assign extRise = extClkS && !extPrev_q;

    always_comb begin
        clkOut_d  = 1'b1;
        data_d    = data_q;
        readyN_d  = readyN_q;
        rdyCnt_d  = (rdyCnt_q != '0) ? rdyCnt_q - 1'b1 : '0;
        txShift_d = txShift_q;
        txLeft_d  = txLeft_q;
        if (!carrierOn) begin
            data_d   = 1'b1;
            readyN_d = 1'b1;
            rdyCnt_d = '0;
        end else if (!modeS) begin
            txLeft_d = '0;
            if (state_q == RX_DATA) begin
                clkOut_d = clkOut_q;
                if (atQuarter) begin
                    data_d   = demodBitS;
                    clkOut_d = 1'b0;
                end else if (atHalf) begin
                    clkOut_d = 1'b1;
                end
            end
            if (byteDone) begin
                readyN_d = 1'b0;
                rdyCnt_d = CNT_W'(QUARTER_CYC - 1);
            end else if (rdyCnt_q == '0) begin
                readyN_d = 1'b1;
            end
        end else begin
            if (byteDone) begin
                readyN_d  = 1'b0;
                rdyCnt_d  = CNT_W'(READY_TIMEOUT_CYC - 1);
                txShift_d = rxShift_q;
                txLeft_d  = BYTE_BITS;
            end else begin
                if (extRise && txLeft_q != '0) begin
                    data_d    = txShift_q[0];
                    txShift_d = {1'b1, txShift_q[7:1]};
                    txLeft_d  = txLeft_q - 1'b1;
                end
                if (extRise || rdyCnt_q == '0) begin
                    readyN_d = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            clkOut_q  <= 1'b1;
            data_q    <= 1'b1;
            readyN_q  <= 1'b1;
            rdyCnt_q  <= '0;
            txShift_q <= SHIFT_RST;
            txLeft_q  <= '0;
            extPrev_q <= 1'b0;
        end else begin
            clkOut_q  <= clkOut_d;
            data_q    <= data_d;
            readyN_q  <= readyN_d;
            rdyCnt_q  <= rdyCnt_d;
            txShift_q <= txShift_d;
            txLeft_q  <= txLeft_d;
            extPrev_q <= extClkS;
        end
    end

    // drive the clock pin only in mode 0
    assign serialBitClockOeN = modeS;
    assign serialBitClockOut = clkOut_q;
    assign serialData        = data_q;
    assign byteReadyN        = readyN_q;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    AST_TONE_RAW_BOTH: assert property (tonePairRaw |-> $past(toneHiS && toneLoS))
        else $error("raw tone high without both tones");
    AST_ALERT_OFF_IN_DEMOD: assert property (demodSelS |=> !tonePairRaw)
        else $error("alert detector active while demodulator selected");
    AST_DISCHARGE_ON_RISE: assert property ($rose(tonePairQualified) |=> guardDischarge [*3])
        else $error("no discharge after qualified alert rise");
    AST_CHARGE_ON_FALL: assert property ($fell(tonePairQualified) |=> guardCharge [*3])
        else $error("no charge after qualified alert fall");
    AST_CARRIER_CAUSE: assert property ($fell(carrierPresentN) |-> $past(carrierAmpS && demodUsable))
        else $error("carrier asserted without amplitude");
    AST_M0_IDLE_HIGH: assert property ((!modeS && !carrierOn) |=>
        (serialBitClockOut && serialData && byteReadyN))
        else $error("mode 0 lines not high without carrier");
    AST_M1_NO_CARRIER: assert property ((modeS && !carrierOn) |=> byteReadyN && $stable(txShift_q))
        else $error("mode 1 update without carrier");
    AST_M0_RISE_MID: assert property ($rose(serialBitClockOut) |->
        $past(!carrierOn || (state_q == RX_DATA && atHalf)))
        else $error("mode 0 clock rise away from mid bit");
    AST_M1_READY_CLEAR: assert property ((modeS && carrierOn && !byteReadyN && extRise && !byteDone)
        |=> byteReadyN)
        else $error("ready not released on first clock rise");
    AST_M1_IGNORE_EXTRA: assert property ((modeS && carrierOn && txLeft_q == '0 && !byteDone)
        |=> $stable(serialData))
        else $error("data changed after last bit");

endmodule // fsk_tone_detect_serial_out

// *** verif/fsk_host_model.sv ***
// Host controller model that clocks caller data out in mode 1
`timescale 1ns/100ps
module fsk_host_model (
    input  wire logic        serialData,
    output logic             hostClk,
    output logic      [15:0] got
);
    // ********
    // Clocking
    // ********
    initial begin
        hostClk = 1'b0;
        got     = 16'h0000;
    end
    // host clocks bits
    // Clock stands still low between reads; sampled late to let data settle
    task automatic clock_in(input int n);
        for (int i = 0; i < n; i++) begin
            hostClk = 1'b1;
            #62.5;
            hostClk = 1'b0;
            #62.5;
            got[i] = serialData;
        end
    endtask
endmodule // fsk_host_model

// *** verif/fsk_tone_detect_serial_out_tb_top.sv ***
// Self-checking bench for the caller data serial output block
`timescale 1ns/100ps
module fsk_tone_detect_serial_out_tb_top
    import fsk_pkg::*;
;
    // *******
    // Harness
    // *******
    localparam int BIT = 80, CON = 200, COFF = 201, RTO = 40;
    logic        ref_clk, sys_rst, demodSelect, outputInterfaceSelect, toneHighDet, toneLowDet;
    logic        carrierAmpOk, demodBit, serialBitClockOut, serialBitClockOeN, serialData, byteReadyN;
    logic        carrierPresentN, tonePairRaw, tonePairQualified, guardDischarge, guardCharge;
    logic        hostClk, pinClk;
    logic [15:0] got;
    logic [7:0]  rxBits;
    int          fails, nCompared, nClk, nRdy, nDis, nChg;

    // Pin level: device drives while its enable is low
    assign pinClk = serialBitClockOeN ? hostClk : serialBitClockOut;

    fsk_tone_detect_serial_out #(.CARRIER_ON_CYC(CON), .CARRIER_OFF_CYC(COFF), .BIT_PERIOD_CYC(BIT),
        .READY_TIMEOUT_CYC(RTO)) u_dut (.ref_clk, .sys_rst, .demodSelect, .outputInterfaceSelect,
        .toneHighDet, .toneLowDet, .carrierAmpOk, .demodBit, .serialBitClockIn(pinClk),
        .serialBitClockOut, .serialBitClockOeN, .serialData, .byteReadyN, .carrierPresentN,
        .tonePairRaw, .tonePairQualified, .guardDischarge, .guardCharge);
    fsk_host_model u_host (.serialData, .hostClk, .got);

    initial ref_clk = 1'b0;
    always #5 ref_clk = ~ref_clk;
    always @(posedge serialBitClockOut) begin
        nClk++;
        rxBits = {serialData, rxBits[7:1]};
    end
    always @(negedge byteReadyN) nRdy++;
    always @(posedge guardDischarge) nDis++;
    always @(posedge guardCharge) nChg++;

    task automatic chk(input logic c, input string m);
        nCompared++;
        if (c !== 1'b1) begin
            fails++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // Frame: start, eight bits LSB first, stop, one idle bit
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            demodBit = f[i];
            cyc(BIT);
        end
        cyc(BIT);
    endtask
    task automatic waitRdy();
        for (int k = 0; k < 2000 && byteReadyN !== 1'b0; k++) cyc(1);
    endtask
    task automatic testDone();
        $display("Compared %0d, failed %0d", nCompared, fails);
        if (fails == 0 && nCompared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // *********
    // Scenarios
    // *********
    task automatic t_alert();
        demodSelect = 1'b1;
        cyc(50);
        demodSelect = 1'b0;
        toneHighDet = 1'b1;
        toneLowDet  = 1'b1;
        cyc(ENABLE_CYC - 50);
        chk(tonePairRaw === 1'b0, "tones during enable");
        cyc(100);
        chk(tonePairRaw === 1'b1, "both tones");
        toneLowDet = 1'b0;
        cyc(50);
        chk(tonePairRaw === 1'b0 && tonePairQualified === 1'b0, "one tone, short burst");
        nDis       = 0;
        toneLowDet = 1'b1;
        cyc(GUARD_PRESENT_CYC - 10);
        chk(tonePairQualified === 1'b0, "early alert");
        cyc(30);
        chk(tonePairQualified === 1'b1 && nDis == 1, "alert on");
        toneLowDet = 1'b0;
        cyc(500);
        toneLowDet = 1'b1;
        cyc(10);
        chk(tonePairQualified === 1'b1 && nChg == 0, "dropout masked");
        toneHighDet = 1'b0;
        toneLowDet  = 1'b0;
        cyc(GUARD_ABSENT_CYC + 30);
        chk(tonePairQualified === 1'b0 && nChg == 1, "alert off");
    endtask
    task automatic t_mode0();
        carrierAmpOk = 1'b1;
        demodSelect  = 1'b1;
        cyc(ENABLE_CYC + CON - 20);
        chk(carrierPresentN === 1'b1, "carrier early");
        cyc(40);
        chk(carrierPresentN === 1'b0, "carrier on");
        nClk = 0;
        nRdy = 0;
        send(8'hA5);
        chk(nClk == 8 && rxBits === 8'hA5, "mode 0 byte");
        chk(nRdy == 1 && byteReadyN === 1'b1, "ready pulse");
        chk(serialBitClockOeN === 1'b0, "device clock");
        // Short low glitch must not open a character
        nClk     = 0;
        nRdy     = 0;
        demodBit = 1'b0;
        cyc(BIT / 4);
        demodBit = 1'b1;
        cyc(2 * BIT);
        chk(nClk == 0 && nRdy == 0 && byteReadyN === 1'b1, "false start");
    endtask
    task automatic t_mode1();
        int k;
        outputInterfaceSelect = 1'b1;
        cyc(10);
        chk(serialBitClockOeN === 1'b1, "host clock");
        fork
            send(8'h3C);
            begin
                waitRdy();
                chk(byteReadyN === 1'b0, "ready low");
                fork
                    u_host.clock_in(10);
                    begin
                        cyc(20);
                        chk(byteReadyN === 1'b1, "ready after edge");
                    end
                join
            end
        join
        chk(got[7:0] === 8'h3C && got[9:8] === 2'h0, "mode 1 byte");
        fork
            send(8'hC3);
            begin
                waitRdy();
                for (k = 0; k < 100 && byteReadyN === 1'b0; k++) cyc(1);
                chk(k >= RTO - 2 && k <= RTO + 2, "ready timeout");
            end
        join
    endtask
    task automatic t_no_carrier();
        carrierAmpOk = 1'b0;
        cyc(COFF - 10);
        chk(carrierPresentN === 1'b0, "dropout held");
        cyc(30);
        chk(carrierPresentN === 1'b1, "carrier off");
        nRdy = 0;
        send(8'h0F);
        chk(nRdy == 0 && byteReadyN === 1'b1, "mode 1 idle");
        outputInterfaceSelect = 1'b0;
        nClk = 0;
        send(8'h0F);
        chk(nClk == 0 && nRdy == 0 && serialData === 1'b1, "mode 0 idle");
        chk(serialBitClockOut === 1'b1 && byteReadyN === 1'b1, "mode 0 lines");
    endtask

    initial begin
        {sys_rst, demodSelect, outputInterfaceSelect, toneHighDet, toneLowDet} = 5'h10;
        {carrierAmpOk, demodBit} = 2'h1;
        {fails, nCompared, nClk, nRdy, nDis, nChg} = '0;
        cyc(16);
        sys_rst = 1'b0;
        chk(serialBitClockOut === 1'b1 && byteReadyN === 1'b1 && carrierPresentN === 1'b1, "reset");
        t_alert();
        t_mode0();
        t_mode1();
        t_no_carrier();
        testDone();
    end
    // Span is about two and a half times the expected run
    initial begin
        #300_000;
        fails++;
        testDone();
    end
endmodule // fsk_tone_detect_serial_out_tb_top
